// ---- itc_defs.svh ----
// Register offsets, descriptor field positions and reset values of the transfer controller
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH

// Register byte offsets
`define ITC_A_CTRL 8'h00
`define ITC_A_VBASE 8'h04
`define ITC_A_IBASE 8'h08
`define ITC_A_DISP 8'h0C
`define ITC_A_SEQ 8'h10
`define ITC_A_STAT 8'h14

// Control register bits
`define ITC_C_STOP 0
`define ITC_C_FULL 1
`define ITC_C_SKIP 2
`define ITC_CTRL_W 3
`define ITC_CTRL_RST 3'h0

// Sequence register fields
`define ITC_S_EN 0
`define ITC_S_CH 15:8

// Status register fields
`define ITC_T_BUSY 0
`define ITC_T_STOP 1
`define ITC_T_SUSP 2
`define ITC_T_CH 15:8

// Descriptor word 0 fields (mode words a, b and c packed)
`define ITC_W_MODE 1:0
`define ITC_W_SIZE 3:2
`define ITC_W_SAM 5:4
`define ITC_W_DAM 7:6
`define ITC_W_RSIDE 8
`define ITC_W_CHAIN 9
`define ITC_W_CHZ 10
`define ITC_W_IRQE 11
`define ITC_W_WRITEBACK_DISABLE_FLAG 12
`define ITC_W_SEQ_END 13
`define ITC_W_INDEX 14
`define ITC_W_DISP 15
`define ITC_W_BSIZE 23:16
`define ITC_W_RSIZE 31:24

// Descriptor layout: four words, 16 bytes
`define ITC_DESC_BYTES 32'h0000_0010
`define ITC_W_SRC 2'h1
`define ITC_W_DST 2'h2
`define ITC_W_CNT 2'h3
`define ITC_LONG 2'h2
`define ITC_FULL_UNITS 9'h100
`define ITC_ZERO32 32'h0000_0000

`endif

// ---- itc_pkg.sv ----
// Types shared by the transfer controller modules
package itc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DESC = 3'b001,
    ST_PTR = 3'b010,
    ST_RDAT = 3'b011,
    ST_WDAT = 3'b100,
    ST_WB = 3'b101,
    ST_NEXT = 3'b110
  } itc_state_type;

  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00,
    MD_REPEAT = 2'b01,
    MD_BLOCK = 2'b10
  } itc_mode_type;

  typedef enum logic [1:0] {
    AM_FIXED = 2'b00,
    AM_INC = 2'b01,
    AM_DEC = 2'b10
  } itc_am_type;
endpackage : itc_pkg

// ---- itc_req_arb.sv ----
// Pending activation flags per channel and lowest-index priority pick
`timescale 1ns/1ps
`default_nettype none
module itc_req_arb #(
  parameter int NUM_CH = 32,
  parameter int CW = $clog2(NUM_CH)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Requests and completions
  input wire logic [NUM_CH-1:0] act_req,
  input wire logic [NUM_CH-1:0] clear,
  // Selected channel
  output logic grant_valid,
  output logic [CW-1:0] grant_idx
);
  logic [NUM_CH-1:0] pend_reg;

  // A request in the same cycle as its clear stays pending
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_pend
      always_ff @(posedge clock) begin
        if (reset) begin
          pend_reg[gi] <= 1'b0;
        end else if (act_req[gi]) begin
          pend_reg[gi] <= 1'b1;
        end else if (clear[gi]) begin
          pend_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    grant_valid = |pend_reg;
    grant_idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        grant_idx = CW'(i);
      end
    end
  end
endmodule : itc_req_arb
`default_nettype wire

// ---- itc_transfer_controller.sv ----
// Interrupt-activated transfer controller engine with register port and memory master
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.svh"
module itc_transfer_controller
  import itc_pkg::*;
#(
  parameter int NUM_CH = 32,
  parameter int CW = $clog2(NUM_CH)
) (
  // System clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data,
  // Activation requests from the interrupt controller
  input wire logic [NUM_CH-1:0] act_req,
  output logic [NUM_CH-1:0] cpu_irq,
  // Memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [1:0] mem_size,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  logic [`ITC_CTRL_W-1:0] ctrl_reg;
  logic [31:0] vbase_reg, ibase_reg, disp_reg, seq_reg, rd_data_reg;
  itc_state_type state_reg;
  logic [CW-1:0] ch_reg, last_ch_reg;
  logic [31:0] daddr_reg, w0_reg, src_reg, dst_reg, data_reg, seq_next_reg;
  logic [15:0] cnt_reg;
  logic [1:0] wi_reg;
  logic [8:0] units_reg;
  logic first_reg, last_ok_reg, susp_reg;
  logic mem_req_reg, mem_we_reg;
  logic [31:0] mem_addr_reg, mem_wdata_reg;
  logic [1:0] mem_size_reg;
  logic [NUM_CH-1:0] cpu_irq_reg, done_reg;
  logic grant_valid;
  logic [CW-1:0] grant_idx;

  assign rd_data = rd_data_reg;
  assign cpu_irq = cpu_irq_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_size = mem_size_reg;

  itc_req_arb #(.NUM_CH(NUM_CH), .CW(CW)) u_arb (
    .clock(clock),
    .reset(reset),
    .act_req(act_req),
    .clear(done_reg),
    .grant_valid(grant_valid),
    .grant_idx(grant_idx)
  );

  function automatic logic [31:0] fix_addr(input logic [31:0] a, input logic full);
    fix_addr = full ? a : {{8{a[23]}}, a[23:0]};
  endfunction : fix_addr

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] am, input logic [1:0] sz);
    logic [31:0] unit;
    unit = `ITC_ZERO32;
    unit[sz] = 1'b1;
    case (am)
      AM_INC: step_addr = a + unit;
      AM_DEC: step_addr = a - unit;
      default: step_addr = a;
    endcase
  endfunction : step_addr

  // Descriptor fields
  itc_mode_type w_mode;
  logic [1:0] w_sz, w_sam, w_dam;
  logic [8:0] bsize9, rsize9;
  logic [31:0] span, src_step, dst_step, src_home, dst_home;
  logic full_mode, seq_hit, skip_hit, resume, need_wb, unit_last;

  always_comb begin
    w_mode = itc_mode_type'(w0_reg[`ITC_W_MODE]);
    // unit size; code 3 is treated as longword
    w_sz = (w0_reg[`ITC_W_SIZE] == 2'h3) ? `ITC_LONG : w0_reg[`ITC_W_SIZE];
    w_sam = w0_reg[`ITC_W_SAM];
    w_dam = w0_reg[`ITC_W_DAM];
    bsize9 = (w0_reg[`ITC_W_BSIZE] == 8'h00) ? `ITC_FULL_UNITS : {1'b0, w0_reg[`ITC_W_BSIZE]};
    rsize9 = (w0_reg[`ITC_W_RSIZE] == 8'h00) ? `ITC_FULL_UNITS : {1'b0, w0_reg[`ITC_W_RSIZE]};
    span = 32'(rsize9) << w_sz;
    full_mode = ctrl_reg[`ITC_C_FULL];
    src_step = step_addr(src_reg, w_sam, w_sz) + (w0_reg[`ITC_W_DISP] ? disp_reg : `ITC_ZERO32);
    dst_step = step_addr(dst_reg, w_dam, w_sz);
    src_home = (w_sam == AM_INC) ? src_reg - span : (w_sam == AM_DEC) ? src_reg + span : src_reg;
    dst_home = (w_dam == AM_INC) ? dst_step - span : (w_dam == AM_DEC) ? dst_step + span : dst_step;
    seq_hit = seq_reg[`ITC_S_EN] && (seq_reg[`ITC_S_CH] == 8'(ch_reg));
    resume = seq_reg[`ITC_S_EN] && (seq_reg[`ITC_S_CH] == 8'(grant_idx)) && susp_reg;
    // same channel, cached descriptor still current
    skip_hit = ctrl_reg[`ITC_C_SKIP] && last_ok_reg && (grant_idx == last_ch_reg) && !resume;
    need_wb = (wi_reg == `ITC_W_SRC) ? (w_sam != AM_FIXED) : (wi_reg == `ITC_W_DST) ? (w_dam != AM_FIXED) : 1'b1;
    unit_last = (units_reg == 9'h001);
  end

  // Register writes
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg <= `ITC_CTRL_RST;
      vbase_reg <= `ITC_ZERO32;
      ibase_reg <= `ITC_ZERO32;
      disp_reg <= `ITC_ZERO32;
      seq_reg <= `ITC_ZERO32;
    end else if (wr_strobe) begin
      case (reg_addr)
        `ITC_A_CTRL: ctrl_reg <= reg_wdata[`ITC_CTRL_W-1:0];
        `ITC_A_VBASE: vbase_reg <= reg_wdata;
        `ITC_A_IBASE: ibase_reg <= reg_wdata;
        `ITC_A_DISP: disp_reg <= reg_wdata;
        `ITC_A_SEQ: seq_reg <= {16'h0000, reg_wdata[`ITC_S_CH], 7'h00, reg_wdata[`ITC_S_EN]};
        default: ;
      endcase
    end
  end

  // Register reads, data valid in the following cycle only
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data_reg <= `ITC_ZERO32;
    end else begin
      rd_data_reg <= `ITC_ZERO32;
      if (rd_strobe) begin
        case (reg_addr)
          `ITC_A_CTRL: rd_data_reg <= 32'(ctrl_reg);
          `ITC_A_VBASE: rd_data_reg <= vbase_reg;
          `ITC_A_IBASE: rd_data_reg <= ibase_reg;
          `ITC_A_DISP: rd_data_reg <= disp_reg;
          `ITC_A_SEQ: rd_data_reg <= seq_reg;
          `ITC_A_STAT: begin
            rd_data_reg[`ITC_T_BUSY] <= (state_reg != ST_IDLE);
            rd_data_reg[`ITC_T_STOP] <= ctrl_reg[`ITC_C_STOP];
            rd_data_reg[`ITC_T_SUSP] <= susp_reg;
            rd_data_reg[`ITC_T_CH] <= 8'(ch_reg);
          end
          default: ;
        endcase
      end
    end
  end

  // Transfer engine
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      ch_reg <= '0;
      last_ch_reg <= '0;
      daddr_reg <= `ITC_ZERO32;
      w0_reg <= `ITC_ZERO32;
      src_reg <= `ITC_ZERO32;
      dst_reg <= `ITC_ZERO32;
      data_reg <= `ITC_ZERO32;
      seq_next_reg <= `ITC_ZERO32;
      cnt_reg <= 16'h0000;
      wi_reg <= 2'h0;
      units_reg <= 9'h000;
      first_reg <= 1'b0;
      last_ok_reg <= 1'b0;
      susp_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= `ITC_ZERO32;
      mem_wdata_reg <= `ITC_ZERO32;
      mem_size_reg <= 2'h0;
      cpu_irq_reg <= '0;
      done_reg <= '0;
    end else begin
      done_reg <= '0;
      cpu_irq_reg <= '0;
      unique case (state_reg)
        ST_IDLE: begin
          // no activation is taken while stopped
          if (!ctrl_reg[`ITC_C_STOP] && grant_valid && !(|done_reg)) begin
            ch_reg <= grant_idx;
            first_reg <= !resume;
            if (skip_hit) begin
              units_reg <= (w_mode == MD_BLOCK) ? bsize9 : 9'h001;
              state_reg <= ST_RDAT;
            end else begin
              daddr_reg <= resume ? seq_next_reg : vbase_reg + (32'(grant_idx) * `ITC_DESC_BYTES);
              wi_reg <= 2'h0;
              state_reg <= ST_DESC;
            end
          end
        end
        ST_DESC: begin
          if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= daddr_reg + 32'({wi_reg, 2'b00});
            mem_size_reg <= `ITC_LONG;
          end else if (mem_ack) begin
            mem_req_reg <= 1'b0;
            case (wi_reg)
              2'h0: w0_reg <= mem_rdata;
              `ITC_W_SRC: src_reg <= mem_rdata;
              `ITC_W_DST: dst_reg <= mem_rdata;
              default: cnt_reg <= mem_rdata[15:0];
            endcase
            if (wi_reg == `ITC_W_CNT) begin
              units_reg <= (w_mode == MD_BLOCK) ? bsize9 : 9'h001;
              state_reg <= ST_RDAT;
            end else begin
              wi_reg <= wi_reg + 2'h1;
            end
          end
        end
        ST_RDAT: begin
          if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= fix_addr(src_reg, full_mode);
            mem_size_reg <= w_sz;
          end else if (mem_ack) begin
            mem_req_reg <= 1'b0;
            data_reg <= mem_rdata;
            src_reg <= src_step;
            state_reg <= ST_WDAT;
          end
        end
        ST_WDAT: begin
          if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b1;
            mem_addr_reg <= fix_addr(dst_reg, full_mode);
            mem_wdata_reg <= data_reg;
            mem_size_reg <= w_sz;
          end else if (mem_ack) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            dst_reg <= dst_step;
            units_reg <= units_reg - 9'h001;
            if (w_mode == MD_REPEAT) begin
              cnt_reg[7:0] <= cnt_reg[7:0] - 8'h01;
              // restore repeating side at end of repeat area
              if (cnt_reg[7:0] == 8'h01) begin
                cnt_reg[7:0] <= rsize9[7:0];
                if (w0_reg[`ITC_W_RSIDE]) begin
                  dst_reg <= dst_home;
                end else begin
                  src_reg <= src_home;
                end
              end
            end else if (w_mode == MD_NORMAL || unit_last) begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
            if (!unit_last) begin
              state_reg <= ST_RDAT;
            end else begin
              wi_reg <= `ITC_W_SRC;
              state_reg <= w0_reg[`ITC_W_WRITEBACK_DISABLE_FLAG] ? ST_NEXT : ST_WB;
            end
          end
        end
        ST_WB: begin
          if (!mem_req_reg) begin
            if (need_wb) begin
              mem_req_reg <= 1'b1;
              mem_we_reg <= 1'b1;
              mem_addr_reg <= daddr_reg + 32'({wi_reg, 2'b00});
              mem_size_reg <= `ITC_LONG;
              mem_wdata_reg <= (wi_reg == `ITC_W_SRC) ? src_reg :
                               (wi_reg == `ITC_W_DST) ? dst_reg : {16'h0000, cnt_reg};
            end else begin
              wi_reg <= wi_reg + 2'h1;
            end
          end else if (mem_ack) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            if (wi_reg == `ITC_W_CNT) begin
              state_reg <= ST_NEXT;
            end else begin
              wi_reg <= wi_reg + 2'h1;
            end
          end
        end
        ST_NEXT: begin
          // interrupt per transfer, or at count end outside repeat mode
          if (w0_reg[`ITC_W_IRQE] || (w_mode != MD_REPEAT && cnt_reg == 16'h0000)) begin
            cpu_irq_reg[ch_reg] <= 1'b1;
          end
          wi_reg <= 2'h0;
          if (seq_hit && first_reg && w0_reg[`ITC_W_INDEX]) begin
            state_reg <= ST_PTR;
          end else if (seq_hit && !w0_reg[`ITC_W_SEQ_END] && w0_reg[`ITC_W_CHAIN]) begin
            daddr_reg <= daddr_reg + `ITC_DESC_BYTES;
            state_reg <= ST_DESC;
          end else if (!seq_hit && w0_reg[`ITC_W_CHAIN] && (!w0_reg[`ITC_W_CHZ] || cnt_reg == 16'h0000)) begin
            // chain always or at zero count
            daddr_reg <= daddr_reg + `ITC_DESC_BYTES;
            state_reg <= ST_DESC;
          end else begin
            // suspend the sequence or close it at its end flag
            if (seq_hit) begin
              susp_reg <= !w0_reg[`ITC_W_SEQ_END];
              seq_next_reg <= daddr_reg + `ITC_DESC_BYTES;
            end
            done_reg[ch_reg] <= 1'b1;
            last_ch_reg <= ch_reg;
            last_ok_reg <= !w0_reg[`ITC_W_CHAIN] && !seq_hit;
            state_reg <= ST_IDLE;
          end
        end
        ST_PTR: begin
          // first data byte picks one of 256 entries
          if (!mem_req_reg) begin
            mem_req_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= ibase_reg + 32'({data_reg[7:0], 2'b00});
            mem_size_reg <= `ITC_LONG;
          end else if (mem_ack) begin
            mem_req_reg <= 1'b0;
            daddr_reg <= mem_rdata;
            first_reg <= 1'b0;
            state_reg <= ST_DESC;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // A register write invalidates the cached descriptor
      if (wr_strobe) begin
        last_ok_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_stop_no_start: assert property (state_reg == ST_IDLE && ctrl_reg[`ITC_C_STOP] |=> state_reg == ST_IDLE)
    else $error("activation taken while stopped");
  a_req_hold: assert property (mem_req_reg && !mem_ack |=> mem_req_reg && $stable(mem_addr_reg))
    else $error("memory request dropped or changed before ack");
  a_short_window: assert property (mem_req_reg && !full_mode && (state_reg == ST_RDAT || state_reg == ST_WDAT)
    |-> mem_addr_reg[31:23] == 9'h000 || mem_addr_reg[31:23] == 9'h1FF)
    else $error("short address outside window");
  a_unit_size: assert property (mem_req_reg && state_reg == ST_RDAT |-> mem_size_reg == w_sz)
    else $error("data size differs from descriptor");
  a_wb_disable: assert property (state_reg == ST_WB |-> !w0_reg[`ITC_W_WRITEBACK_DISABLE_FLAG])
    else $error("write-back while disabled");
  a_wb_fixed: assert property (state_reg == ST_WB && mem_req_reg && wi_reg == `ITC_W_SRC |-> w_sam != AM_FIXED)
    else $error("fixed source written back");
  a_normal_single: assert property (state_reg == ST_WDAT && mem_ack && w_mode == MD_NORMAL
    |=> state_reg != ST_RDAT)
    else $error("normal mode moved a second unit");
  a_irq_single: assert property ($onehot0(cpu_irq_reg))
    else $error("interrupt on more than one channel");
  a_index_addr: assert property (state_reg == ST_PTR && mem_req_reg
    |-> mem_addr_reg == ibase_reg + 32'({data_reg[7:0], 2'b00}))
    else $error("index table address wrong");
  a_block_units: assert property (state_reg == ST_RDAT |-> units_reg != 9'h000 && units_reg <= `ITC_FULL_UNITS)
    else $error("block unit count out of range");
  a_done_pulse: assert property (|done_reg |=> done_reg == '0 && state_reg == ST_IDLE)
    else $error("completion not a single pulse");

  c_block_run: cover property (state_reg == ST_WDAT && mem_ack && w_mode == MD_BLOCK && unit_last);
  c_chain: cover property (state_reg == ST_NEXT ##1 state_reg == ST_DESC);
  c_index: cover property (state_reg == ST_PTR && mem_ack);
  c_skip: cover property (state_reg == ST_IDLE ##1 state_reg == ST_RDAT);
endmodule : itc_transfer_controller
`default_nettype wire

// ---- itc_mem_model.sv ----
// Behavioural on-chip memory answering the transfer controller's master port
`timescale 1ns/1ps
`default_nettype none
module itc_mem_model (
  // Clock
  input wire logic clock,
  // Master port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] mem_size,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Wait states before each answer
  input wire logic [3:0] wait_cycles
);
  logic [7:0] mem [0:4095];
  logic [3:0] wait_count_reg = 4'h0;
  logic [11:0] base;
  logic [2:0] units;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0000_0000;
  assign base = mem_addr[11:0];
  assign units = (mem_size == 2'h0) ? 3'h1 : (mem_size == 2'h1) ? 3'h2 : 3'h4;
  // one master port on the system clock
  always @(posedge clock) begin
    if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      wait_count_reg <= 4'h0;
      // Released read data must not keep its value, or a late capture would pass
      mem_rdata <= ~mem_rdata;
    end else if (wait_count_reg == wait_cycles) begin
      mem_ack <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        mem_rdata[8*i +: 8] <= (i < units) ? mem[base + i] : 8'h00;
        if (mem_we && i < units) mem[base + i] <= mem_wdata[8*i +: 8];
      end
    end else begin
      wait_count_reg <= wait_count_reg + 4'h1;
    end
  end
endmodule : itc_mem_model
`default_nettype wire

// ---- tb_itc_transfer_controller.sv ----
// Self-checking bench for the transfer controller: register tasks, descriptors and scenarios
`timescale 1ns/1ps
`default_nettype none
`include "itc_defs.svh"
module tb_itc_transfer_controller
  import itc_pkg::*;
;
  localparam int SRC = 32'h0000_0800;
  localparam int DST = 32'h0000_0C00;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [31:0] act_req = 32'h0000_0000;
  logic [3:0] wait_cycles = 4'h0;
  logic [31:0] irq_seen = 32'h0000_0000;
  logic [31:0] rd_data, cpu_irq, mem_addr, mem_wdata, mem_rdata, r;
  logic mem_req, mem_we, mem_ack;
  logic [1:0] mem_size;
  int miscompares = 0;
  int compares = 0;

  itc_transfer_controller u_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .act_req(act_req), .cpu_irq(cpu_irq),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  itc_mem_model u_mem (.clock(clock), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .wait_cycles(wait_cycles));

  initial begin
    forever #2 clock = ~clock;
  end
  // Interrupt pulses last one cycle, so they are collected as they pass
  always @(posedge clock) begin
    if (!reset) irq_seen <= irq_seen | cpu_irq;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic check32(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : check32
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string name);
    logic [31:0] d;
    rd(a, d);
    check32(name, e, d);
  endtask : chk
  function automatic logic [31:0] get32(input int a);
    return {u_mem.mem[a+3], u_mem.mem[a+2], u_mem.mem[a+1], u_mem.mem[a]};
  endfunction : get32
  task automatic put32(input int a, input logic [31:0] d);
    {u_mem.mem[a+3], u_mem.mem[a+2], u_mem.mem[a+1], u_mem.mem[a]} = d;
  endtask : put32
  // Flags: bit0 repeat side, bit1 chain, bit2 chain on zero, bit3 irq each, bit4 no write-back
  function automatic logic [31:0] mkw(input itc_mode_type m, input logic [1:0] sz, input itc_am_type sam,
      input itc_am_type dam, input logic [7:0] flags, input logic [7:0] bsize, input logic [7:0] rsize);
    return {rsize, bsize, flags, dam, sam, sz, m};
  endfunction : mkw
  task automatic desc(input int ch, input logic [31:0] w0, input int s, input int d, input logic [15:0] n);
    put32(256 + ch * 16, w0);
    put32(260 + ch * 16, s);
    put32(264 + ch * 16, d);
    put32(268 + ch * 16, {16'h0000, n});
  endtask : desc
  task automatic act(input int ch, input bit pulse);
    int k;
    @(posedge clock);
    act_req[ch] <= pulse;
    @(posedge clock);
    act_req <= 32'h0000_0000;
    repeat (4) @(posedge clock);
    // Bound covers a 256-unit block with memory wait states
    for (k = 0; k < 4000; k++) begin
      rd(`ITC_A_STAT, r);
      if (r[`ITC_T_BUSY] === 1'b0) break;
    end
    if (k == 4000) begin
      miscompares++;
      results();
    end
  endtask : act

  initial begin
    for (int i = 0; i < 4096; i++) u_mem.mem[i] = (i >= SRC && i < DST) ? i[7:0] ^ 8'h5A : 8'h00;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    chk(`ITC_A_CTRL, 32'h0000_0000, "ctrl");
    chk(`ITC_A_STAT, 32'h0000_0000, "status");
    wr(8'h3C, 32'hFFFF_FFFF);
    chk(8'h3C, 32'h0000_0000, "unmapped");
    wr(`ITC_A_VBASE, 32'h0000_0100);
    chk(`ITC_A_VBASE, 32'h0000_0100, "vbase");
    desc(3, mkw(MD_NORMAL, `ITC_LONG, AM_INC, AM_INC, 8'h00, 8'h01, 8'h01), SRC, DST, 16'h0002);
    act(3, 1'b1);
    check32("normal dst0", get32(SRC), get32(DST));
    check32("normal dst1", 32'h0000_0000, get32(DST + 4));
    check32("normal count", 32'h0000_0001, get32(268 + 48));
    check32("normal src", SRC + 4, get32(260 + 48));
    check32("no irq", 32'h0000_0000, irq_seen);
    wait_cycles <= 4'h3;
    act(3, 1'b1);
    check32("slow dst1", get32(SRC + 4), get32(DST + 4));
    check32("count irq", 32'h0000_0008, irq_seen);
    // Block size zero means the full 256 units
    desc(4, mkw(MD_BLOCK, 2'h0, AM_INC, AM_INC, 8'h00, 8'h00, 8'h01), SRC + 256, DST + 256, 16'h0001);
    act(4, 1'b1);
    check32("block last", get32(SRC + 508), get32(DST + 508));
    check32("block past", 32'h0000_0000, get32(DST + 512));
    check32("block irq", 32'h0000_0018, irq_seen);
    desc(6, mkw(MD_NORMAL, 2'h1, AM_FIXED, AM_INC, 8'h12, 8'h01, 8'h01), SRC + 32, DST + 32, 16'h0005);
    desc(7, mkw(MD_NORMAL, 2'h1, AM_INC, AM_INC, 8'h00, 8'h01, 8'h01), SRC + 48, DST + 48, 16'h0002);
    act(6, 1'b1);
    check32("word unit", get32(SRC + 32) & 32'h0000_FFFF, get32(DST + 32));
    check32("chained", get32(SRC + 48) & 32'h0000_FFFF, get32(DST + 48));
    check32("wb disabled", 32'h0000_0005, get32(268 + 96));
    check32("chain count", 32'h0000_0001, get32(268 + 112));
    desc(10, mkw(MD_REPEAT, 2'h0, AM_INC, AM_FIXED, 8'h00, 8'h01, 8'h02), SRC + 64, DST + 64, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      act(10, 1'b1);
      check32("repeat", {24'h00_0000, u_mem.mem[SRC + 64 + (i % 2)]}, get32(DST + 64));
    end
    // A stopped engine keeps the request pending and serves it once released
    wr(`ITC_A_CTRL, 32'h0000_0001);
    desc(9, mkw(MD_NORMAL, 2'h0, AM_INC, AM_INC, 8'h00, 8'h01, 8'h01), SRC + 80, DST + 80, 16'h0003);
    act(9, 1'b1);
    rd(`ITC_A_STAT, r);
    check32("stopped flag", 32'h0000_0002, r & 32'h0000_0003);
    check32("stopped dst", 32'h0000_0000, get32(DST + 80));
    wr(`ITC_A_CTRL, 32'h0000_0000);
    act(9, 1'b0);
    check32("resumed dst", {24'h00_0000, u_mem.mem[SRC + 80]}, get32(DST + 80));
    chk(`ITC_A_STAT, 32'h0000_0900, "last channel");
    check32("final irq", 32'h0000_0018, irq_seen);
    // Read skip: a source word changed in memory is ignored while the cached descriptor is reused
    wr(`ITC_A_CTRL, 32'h0000_0004);
    wr(`ITC_A_DISP, 32'h0000_0002);
    chk(`ITC_A_DISP, 32'h0000_0002, "displacement");
    desc(12, mkw(MD_NORMAL, 2'h0, AM_INC, AM_INC, 8'h88, 8'h01, 8'h01), SRC + 96, DST + 96, 16'h0003);
    act(12, 1'b1);
    put32(260 + 192, SRC + 200);
    act(12, 1'b1);
    check32("skip dst", {16'h0000, u_mem.mem[SRC + 99], u_mem.mem[SRC + 96]}, get32(DST + 96));
    check32("skip src", SRC + 102, get32(260 + 192));
    // Sequence on channel 14: its first byte picks the entry, the second part waits for a new request
    wr(`ITC_A_CTRL, 32'h0000_0000);
    wr(`ITC_A_IBASE, 32'h0000_0300);
    wr(`ITC_A_SEQ, 32'h0000_0E01);
    chk(`ITC_A_SEQ, 32'h0000_0E01, "sequence");
    desc(14, mkw(MD_NORMAL, 2'h0, AM_INC, AM_INC, 8'h40, 8'h01, 8'h01), SRC + 112, DST + 112, 16'h0001);
    put32(32'h0000_0300 + 4 * u_mem.mem[SRC + 112], 32'h0000_0380);
    desc(40, mkw(MD_NORMAL, 2'h0, AM_INC, AM_INC, 8'h00, 8'h01, 8'h01), SRC + 120, DST + 120, 16'h0001);
    desc(41, mkw(MD_NORMAL, 2'h0, AM_INC, AM_INC, 8'h20, 8'h01, 8'h01), SRC + 121, DST + 121, 16'h0001);
    act(14, 1'b1);
    check32("seq first", {24'h00_0000, u_mem.mem[SRC + 112]}, get32(DST + 112));
    check32("seq part", {24'h00_0000, u_mem.mem[SRC + 120]}, get32(DST + 120));
    chk(`ITC_A_STAT, 32'h0000_0E04, "suspended");
    act(14, 1'b1);
    check32("seq rest", {16'h0000, u_mem.mem[SRC + 121], u_mem.mem[SRC + 120]}, get32(DST + 120));
    chk(`ITC_A_STAT, 32'h0000_0E00, "seq closed");
    check32("all irq", 32'h0000_5018, irq_seen);
    results();
  end
endmodule : tb_itc_transfer_controller
`default_nettype wire
